/* logic/macc_pkg.sv */
package macc_pkg;
    // system clock phase divider: three phases per memory clock time
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned PHASE_COUNT = 3;
    localparam logic [1:0] PHASE_LAST = 2'h2;
    localparam logic [1:0] PHASE_P2 = 2'h1;
    localparam logic [1:0] PHASE_P3 = 2'h2;
    // board interface widths
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CHECK_W = 6;
    localparam int unsigned WADDR_W = 12;
    localparam int unsigned REFADDR_W = 6;
    localparam int unsigned BANK_W = 3;
    localparam int unsigned SWAP_LO = 10;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned BYTE_W = 8;
    // state bit codes (bit a, bit b)
    localparam logic [1:0] ST_IDLE = 2'h0;
    localparam logic [1:0] ST_SELECT = 2'h2;
    localparam logic [1:0] ST_TRANSFER = 2'h3;
    localparam logic [1:0] ST_FINISH = 2'h1;
    typedef enum {MACC_IDLE, MACC_SELECT, MACC_TRANSFER, MACC_FINISH} macc_state_t;
endpackage

/* logic/macc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - fixed priority per cycle: refresh, then channel, then processor
// - refresh request clears both grant flip-flops at next edge
// - both grants clear: start board refresh, block channel clock
// - low registered master reset holds refresh granted through a burst
// - channel request without power fail clears latch; grant follows at the next phase-2 time in idle
// - no channel request or power fail sets latch; processor granted
// - every operation walks all four states, three phase-2 times
// - state bits a,b: idle 00, select 10, transfer 11, finish 01
// - entering idle clears the processor cycle-complete flag
// - idle leaves for select on granted request or refresh
// - chip enable follows state bit a exactly
// - select advances to transfer on next phase-2 pulse
// - transfer of a fetch pulses the read-data strobe
// - transfer of a store writes unless a processor cycle is privileged and protected
// - transfer always advances to finish on next phase-2 pulse
// - finish sets complete flag for processor cycles; idle on phase-3
// - board word is 16 data plus 6 check bits, written active low
// - 12 low address bits out active low; refresh makes upper six
// - three board selects and 3-bit bank codes, third bit least significant
// - swap test low trades data 10-15 with check bits both ways
// - address counter exports low-byte carry, takes high-byte carry in
module macc_ctrl (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // power and arbitration inputs
    input wire logic i_registered_master_reset,
    input wire logic i_power_failing_n,
    input wire logic i_refresh_request,
    input wire logic [5:0] i_refresh_address,
    // channel side
    input wire logic i_channel_memory_request_n,
    input wire logic i_channel_store,
    input wire logic [15:0] i_channel_address,
    input wire logic [15:0] i_channel_write_data,
    // processor side
    input wire logic i_proc_cycle_request_n,
    input wire logic i_proc_store_select,
    input wire logic i_proc_addr_load_n,
    input wire logic i_proc_addr_inc_n,
    input wire logic [15:0] i_proc_load_address,
    input wire logic [15:0] i_proc_write_data,
    input wire logic i_privileged_mode,
    input wire logic i_target_protected,
    // test inputs
    input wire logic i_check_swap_test_n,
    input wire logic i_addr_high_carry_in,
    input wire logic [5:0] i_write_check,
    // board side inputs
    input wire logic [15:0] i_board_read_data,
    input wire logic [5:0] i_board_read_check,
    input wire logic i_address_accepted_n,
    // arbitration outputs
    output logic o_proc_access_grant,
    output logic o_channel_access_grant,
    output logic o_refresh_clock_block_n,
    output logic o_refresh_start_to_boards_n,
    output logic o_proc_cycle_complete_flag,
    output logic [1:0] o_cycle_state,
    output logic o_phase_p2,
    // board control
    output logic o_chip_enable,
    output logic o_write_strobe_n,
    output logic o_read_data_strobe_n,
    output logic [15:0] o_board_write_data_n,
    output logic [5:0] o_board_write_check_n,
    output logic [11:0] o_board_word_address_n,
    output logic o_board_one_select,
    output logic o_board_two_select,
    output logic o_board_three_select,
    output logic [2:0] o_board_one_bank_code,
    output logic [2:0] o_board_two_bank_code,
    // read bus and test outputs
    output logic [15:0] o_read_bus,
    output logic [5:0] o_read_check,
    output logic o_address_accepted,
    output logic o_addr_low_carry_out,
    output logic [15:0] o_proc_address
);
    logic [1:0] phase_reg;
    logic p2_en;
    logic p3_en;
    logic channel_request_latch;
    logic refresh_grant_internal;
    logic refresh_grant_internal_n;
    logic cycle_state_bit_a;
    logic cycle_state_bit_b;
    logic proc_cycle_reg;
    logic store_reg;
    logic refresh_cycle_reg;
    logic [15:0] cyc_addr;
    logic [15:0] cyc_wdata;
    logic [15:0] wdata_sel;
    logic [5:0] wcheck_sel;
    logic go_cycle;
    logic [8:0] low_sum;
    macc_pkg::macc_state_t state_reg;
    macc_pkg::macc_state_t state_next;

    // phase divider gives the phase-2 and phase-3 enables
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || phase_reg == macc_pkg::PHASE_LAST) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign p2_en = (phase_reg == macc_pkg::PHASE_P2);
    assign p3_en = (phase_reg == macc_pkg::PHASE_P3);

    // grants load only in idle, but refresh or low master reset clears them mid-cycle; cycle address is held from start
    // latch low on channel request without power fail
    // latch high otherwise, giving processor access
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            channel_request_latch <= 1'b1;
        end else if (p2_en && state_reg == macc_pkg::MACC_IDLE) begin
            channel_request_latch <= i_channel_memory_request_n || !i_power_failing_n;
        end
    end

    // refresh first, channel next, processor last
    // low master reset keeps grants disabled
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_proc_access_grant <= 1'b0;
            o_channel_access_grant <= 1'b0;
        end else if (i_refresh_request || !i_registered_master_reset) begin
            o_proc_access_grant <= 1'b0;
            o_channel_access_grant <= 1'b0;
        end else if (p2_en && state_reg == macc_pkg::MACC_IDLE) begin
            o_channel_access_grant <= !channel_request_latch;
            o_proc_access_grant <= channel_request_latch;
        end
    end

    // refresh recognised with both grants clear
    assign refresh_grant_internal = !o_proc_access_grant && !o_channel_access_grant;
    assign refresh_grant_internal_n = !refresh_grant_internal;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_refresh_clock_block_n <= 1'b1;
            o_refresh_start_to_boards_n <= 1'b1;
        end else begin
            o_refresh_clock_block_n <= refresh_grant_internal_n;
            o_refresh_start_to_boards_n <= refresh_grant_internal_n;
        end
    end

    // start on granted request or refresh grant
    assign go_cycle = (o_channel_access_grant && !i_channel_memory_request_n)
        || (o_proc_access_grant && !i_proc_cycle_request_n)
        || refresh_grant_internal;

    // four states, one per phase-2 time except finish
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            macc_pkg::MACC_IDLE: begin
                if (p2_en && go_cycle) begin
                    state_next = macc_pkg::MACC_SELECT;
                end
            end
            // select to transfer on phase 2
            macc_pkg::MACC_SELECT: begin
                if (p2_en) begin
                    state_next = macc_pkg::MACC_TRANSFER;
                end
            end
            // transfer always to finish on phase 2
            macc_pkg::MACC_TRANSFER: begin
                if (p2_en) begin
                    state_next = macc_pkg::MACC_FINISH;
                end
            end
            // back to idle on phase 3
            macc_pkg::MACC_FINISH: begin
                if (p3_en) begin
                    state_next = macc_pkg::MACC_IDLE;
                end
            end
            default: begin
                state_next = macc_pkg::MACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= macc_pkg::MACC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        case (state_next)
            macc_pkg::MACC_SELECT: {cycle_state_bit_a, cycle_state_bit_b} = macc_pkg::ST_SELECT;
            macc_pkg::MACC_TRANSFER: {cycle_state_bit_a, cycle_state_bit_b} = macc_pkg::ST_TRANSFER;
            macc_pkg::MACC_FINISH: {cycle_state_bit_a, cycle_state_bit_b} = macc_pkg::ST_FINISH;
            default: {cycle_state_bit_a, cycle_state_bit_b} = macc_pkg::ST_IDLE;
        endcase
    end

    // chip enable tracks state bit a
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_cycle_state <= macc_pkg::ST_IDLE;
            o_chip_enable <= 1'b0;
            o_phase_p2 <= 1'b0;
        end else begin
            o_cycle_state <= {cycle_state_bit_a, cycle_state_bit_b};
            o_chip_enable <= cycle_state_bit_a;
            o_phase_p2 <= (phase_reg == macc_pkg::PHASE_P2 - 2'h1);
        end
    end

    // capture cycle kind, address and data when the cycle starts
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            proc_cycle_reg <= 1'b0;
            refresh_cycle_reg <= 1'b0;
            store_reg <= 1'b0;
            cyc_addr <= 16'h0000;
            cyc_wdata <= 16'h0000;
        end else if (state_reg == macc_pkg::MACC_IDLE && state_next == macc_pkg::MACC_SELECT) begin
            proc_cycle_reg <= o_proc_access_grant;
            // kind held: grants may move at the start edge
            refresh_cycle_reg <= refresh_grant_internal;
            cyc_wdata <= o_channel_access_grant ? i_channel_write_data : i_proc_write_data;
            if (o_channel_access_grant) begin
                store_reg <= i_channel_store;
                cyc_addr <= i_channel_address;
            end else if (o_proc_access_grant) begin
                store_reg <= i_proc_store_select;
                cyc_addr <= o_proc_address;
            end else begin
                // refresh supplies the upper six word-address bits
                store_reg <= 1'b0;
                cyc_addr <= {4'h0, i_refresh_address, 6'h00};
            end
        end
    end

    // clear flag on idle entry; set in finish for processor cycles
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_proc_cycle_complete_flag <= 1'b0;
        end else if (state_next == macc_pkg::MACC_FINISH && proc_cycle_reg) begin
            o_proc_cycle_complete_flag <= 1'b1;
        end else if (state_next == macc_pkg::MACC_IDLE && state_reg != macc_pkg::MACC_IDLE) begin
            o_proc_cycle_complete_flag <= 1'b0;
        end
    end

    // swap data 10-15 into check positions on store
    always_comb begin
        wdata_sel = cyc_wdata;
        wcheck_sel = i_write_check;
        if (!i_check_swap_test_n) begin
            wcheck_sel = cyc_wdata[15:10];
        end
    end

    // read strobe in fetch transfer; write gated by protection
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_read_data_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
        end else begin
            o_read_data_strobe_n <= !(state_next == macc_pkg::MACC_TRANSFER
                && state_reg != macc_pkg::MACC_TRANSFER && !store_reg && !refresh_cycle_reg);
            o_write_strobe_n <= !(state_next == macc_pkg::MACC_TRANSFER && store_reg
                && !(i_privileged_mode && i_target_protected && proc_cycle_reg));
        end
    end

    // active-low write word; low 12 address bits inverted
    // board selects and bank codes, msb first
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_board_write_data_n <= 16'hffff;
            o_board_write_check_n <= 6'h3f;
            o_board_word_address_n <= 12'hfff;
            o_board_one_select <= 1'b0;
            o_board_two_select <= 1'b0;
            o_board_three_select <= 1'b0;
            o_board_one_bank_code <= 3'h0;
            o_board_two_bank_code <= 3'h0;
        end else begin
            o_board_write_data_n <= ~wdata_sel;
            o_board_write_check_n <= ~wcheck_sel;
            o_board_word_address_n <= ~cyc_addr[11:0];
            o_board_one_select <= !cyc_addr[15];
            o_board_two_select <= cyc_addr[15] && !(&cyc_addr[14:13]);
            o_board_three_select <= cyc_addr[15] && (&cyc_addr[14:13]);
            o_board_one_bank_code <= cyc_addr[14:12];
            o_board_two_bank_code <= cyc_addr[14:12];
        end
    end

    // read latches hold until the next fetch strobe
    // check bits replace data 10-15 on reads under test
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_read_bus <= 16'h0000;
            o_read_check <= 6'h00;
            o_address_accepted <= 1'b0;
        end else begin
            o_address_accepted <= !i_address_accepted_n;
            if (!o_read_data_strobe_n) begin
                o_read_check <= i_board_read_check;
                if (!i_check_swap_test_n) begin
                    o_read_bus <= {i_board_read_check, i_board_read_data[9:0]};
                end else begin
                    o_read_bus <= i_board_read_data;
                end
            end
        end
    end

    // split counter with external carry between bytes
    assign low_sum = {1'b0, o_proc_address[7:0]} + 9'h001;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_proc_address <= 16'h0000;
            o_addr_low_carry_out <= 1'b0;
        end else begin
            o_addr_low_carry_out <= &o_proc_address[7:0];
            if (!i_proc_addr_load_n) begin
                o_proc_address <= i_proc_load_address;
            end else if (!i_proc_addr_inc_n && p3_en) begin
                o_proc_address[7:0] <= low_sum[7:0];
                o_proc_address[15:8] <= o_proc_address[15:8] + {7'h00, i_addr_high_carry_in};
            end
        end
    end
endmodule
`default_nettype wire

/* tb/macc_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module macc_ctrl_checker (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // watched outputs
    input wire logic o_proc_access_grant,
    input wire logic o_channel_access_grant,
    input wire logic o_refresh_clock_block_n,
    input wire logic o_refresh_start_to_boards_n,
    input wire logic o_proc_cycle_complete_flag,
    input wire logic [1:0] o_cycle_state,
    input wire logic o_chip_enable,
    input wire logic o_write_strobe_n,
    input wire logic o_read_data_strobe_n
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    logic idle, sel, xfer, fin, nogrant;
    assign idle = o_cycle_state == macc_pkg::ST_IDLE;
    assign sel = o_cycle_state == macc_pkg::ST_SELECT;
    assign xfer = o_cycle_state == macc_pkg::ST_TRANSFER;
    assign fin = o_cycle_state == macc_pkg::ST_FINISH;
    assign nogrant = !o_proc_access_grant && !o_channel_access_grant;
    a_one_grant: assert property (!(o_proc_access_grant && o_channel_access_grant))
        else $error("both access grants high");
    a_refresh_start: assert property (nogrant |=> !o_refresh_start_to_boards_n)
        else $error("no refresh start with both grants clear");
    a_refresh_hidden: assert property (nogrant |=> !o_refresh_clock_block_n)
        else $error("channel clock not blocked in refresh");
    a_enable_follows: assert property (o_chip_enable == o_cycle_state[1])
        else $error("chip enable differs from state bit a");
    a_select_wait: assert property ($rose(sel) |-> sel [*3] ##1 xfer)
        else $error("select did not last one phase-2 time");
    a_transfer_hold: assert property ($rose(xfer) |-> xfer [*3] ##1 fin)
        else $error("transfer did not advance to finish");
    a_finish_bound: assert property ($rose(fin) |-> ##[1:3] idle)
        else $error("finish did not return to idle");
    a_flag_source: assert property ($rose(o_proc_cycle_complete_flag) |-> fin && o_proc_access_grant)
        else $error("complete flag set outside processor finish");
    a_flag_clear: assert property ($rose(idle) |-> ##[0:1] !o_proc_cycle_complete_flag)
        else $error("complete flag kept in idle");
    a_read_pulse: assert property ($fell(o_read_data_strobe_n) |-> xfer ##1 o_read_data_strobe_n)
        else $error("read strobe not a transfer pulse");
    a_write_window: assert property (!o_write_strobe_n |-> xfer)
        else $error("write strobe outside transfer");
    c_proc_store: cover property (!o_write_strobe_n && o_proc_access_grant);
    c_fetch: cover property ($fell(o_read_data_strobe_n));
    c_refresh: cover property (sel && nogrant);
    c_channel: cover property (sel && o_channel_access_grant);
endmodule
bind macc_ctrl macc_ctrl_checker i_macc_ctrl_checker (.*);
`default_nettype wire

/* tb/macc_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module macc_board_model (
    // controller side
    input wire logic i_clk_sys,
    input wire logic i_chip_enable,
    input wire logic i_write_strobe_n,
    input wire logic [11:0] i_board_word_address_n,
    input wire logic [15:0] i_board_write_data_n,
    input wire logic [5:0] i_board_write_check_n,
    input wire logic i_board_select,
    // board answers
    output logic [15:0] o_board_read_data,
    output logic [5:0] o_board_read_check,
    output logic o_address_accepted_n
);
    logic [21:0] mem_reg [16];
    logic [21:0] last_reg;
    logic [3:0] word;
    assign word = ~i_board_word_address_n[3:0];
    // word of data plus check, active low in
    always_ff @(posedge i_clk_sys) begin
        if (i_chip_enable && !i_write_strobe_n) begin
            mem_reg[word] <= {~i_board_write_check_n, ~i_board_write_data_n};
        end
        if (i_chip_enable) begin
            last_reg <= mem_reg[word];
        end
    end
    // deselected lines flip so stale data never matches
    assign {o_board_read_check, o_board_read_data} = i_chip_enable ? mem_reg[word] : ~last_reg;
    // accepted low only when a board takes the address
    assign o_address_accepted_n = !(i_chip_enable && i_board_select);
endmodule
`default_nettype wire

/* tb/macc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    miscompares++; $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module macc_ctrl_bench;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, i_registered_master_reset = 1'b1;
    logic i_power_failing_n = 1'b1, i_refresh_request = 1'b0, i_channel_memory_request_n = 1'b1;
    logic i_channel_store = 1'b0, i_proc_cycle_request_n = 1'b1, i_proc_store_select = 1'b0;
    logic i_proc_addr_load_n = 1'b1, i_proc_addr_inc_n = 1'b1, i_privileged_mode = 1'b0;
    logic i_target_protected = 1'b0, i_check_swap_test_n = 1'b1, i_addr_high_carry_in = 1'b0;
    logic [5:0] i_refresh_address = 6'h00, i_write_check = 6'h2d;
    logic [15:0] i_channel_address = 16'h0000, i_channel_write_data = 16'h0000;
    logic [15:0] i_proc_load_address = 16'h0000, i_proc_write_data = 16'h0000;
    logic [15:0] i_board_read_data, o_board_write_data_n, o_read_bus, o_proc_address;
    logic [5:0] i_board_read_check, o_board_write_check_n, o_read_check;
    logic i_address_accepted_n, o_proc_access_grant, o_channel_access_grant, o_phase_p2;
    logic o_refresh_clock_block_n, o_refresh_start_to_boards_n, o_proc_cycle_complete_flag;
    logic o_chip_enable, o_write_strobe_n, o_read_data_strobe_n, o_board_one_select;
    logic o_board_two_select, o_board_three_select, o_address_accepted, o_addr_low_carry_out;
    logic [1:0] o_cycle_state;
    logic [11:0] o_board_word_address_n;
    logic [2:0] o_board_one_bank_code, o_board_two_bank_code;
    logic wr_seen = 1'b0, flag_seen = 1'b0;
    int miscompares = 0, samples_checked = 0;
    macc_ctrl i_macc_ctrl (.*);
    macc_board_model i_macc_board_model (
        .i_clk_sys(i_clk_sys),
        .i_chip_enable(o_chip_enable),
        .i_write_strobe_n(o_write_strobe_n),
        .i_board_word_address_n(o_board_word_address_n),
        .i_board_write_data_n(o_board_write_data_n),
        .i_board_write_check_n(o_board_write_check_n),
        .i_board_select(o_board_one_select | o_board_two_select | o_board_three_select),
        .o_board_read_data(i_board_read_data),
        .o_board_read_check(i_board_read_check),
        .o_address_accepted_n(i_address_accepted_n)
    );
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // backplane loop of the address counter carry
    always @(posedge i_clk_sys) i_addr_high_carry_in <= o_addr_low_carry_out;
    always @(negedge i_clk_sys) begin
        if (o_write_strobe_n === 1'b0) wr_seen = 1'b1;
        if (o_proc_cycle_complete_flag === 1'b1) flag_seen = 1'b1;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        stop_test();
    end
    task automatic wait_st(input logic [1:0] s);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (o_cycle_state !== s && n < 60) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK("cycle state", s, o_cycle_state);
    endtask
    task automatic close_cycle();
        wait_st(macc_pkg::ST_FINISH);
        wait_st(macc_pkg::ST_IDLE);
        @(negedge i_clk_sys);
        `CHK("phase two", 1'b1, o_phase_p2);
        @(negedge i_clk_sys);
    endtask
    task automatic proc_cycle(input logic st, input logic [15:0] a, input logic [15:0] d);
        wr_seen = 1'b0;
        flag_seen = 1'b0;
        @(posedge i_clk_sys);
        i_proc_addr_load_n <= 1'b0;
        i_proc_load_address <= a;
        i_proc_write_data <= d;
        i_proc_store_select <= st;
        repeat (3) @(posedge i_clk_sys);
        i_proc_addr_load_n <= 1'b1;
        // active-low request, store line high writes
        i_proc_cycle_request_n <= 1'b0;
        wait_st(macc_pkg::ST_SELECT);
        @(posedge i_clk_sys);
        i_proc_cycle_request_n <= 1'b1;
        wait_st(macc_pkg::ST_TRANSFER);
    endtask
    task automatic t_proc();
        proc_cycle(1'b1, 16'h5a7c, 16'hc3a5);
        `CHK("write data", ~16'hc3a5, o_board_write_data_n);
        `CHK("write check", ~6'h2d, o_board_write_check_n);
        `CHK("word address", ~12'ha7c, o_board_word_address_n);
        `CHK("board one", 1'b1, o_board_one_select);
        `CHK("bank one", 3'h5, o_board_one_bank_code);
        `CHK("addr accepted", 1'b1, o_address_accepted);
        close_cycle();
        `CHK("addr released", 1'b0, o_address_accepted);
        `CHK("store strobe", 1'b1, wr_seen);
        `CHK("flag after idle", 1'b0, o_proc_cycle_complete_flag);
        proc_cycle(1'b0, 16'h5a7c, 16'h0000);
        close_cycle();
        `CHK("read bus", 16'hc3a5, o_read_bus);
        `CHK("read check", 6'h2d, o_read_check);
        `CHK("address reg", 16'h5a7c, o_proc_address);
        `CHK("complete flag", 1'b1, flag_seen);
    endtask
    task automatic t_protect();
        @(posedge i_clk_sys);
        i_privileged_mode <= 1'b1;
        i_target_protected <= 1'b1;
        proc_cycle(1'b1, 16'h5a7c, 16'h1111);
        close_cycle();
        `CHK("protected strobe", 1'b0, wr_seen);
        @(posedge i_clk_sys);
        i_privileged_mode <= 1'b0;
        i_target_protected <= 1'b0;
        proc_cycle(1'b0, 16'h5a7c, 16'h0000);
        close_cycle();
        `CHK("protected word", 16'hc3a5, o_read_bus);
    endtask
    task automatic t_swap();
        @(posedge i_clk_sys);
        i_check_swap_test_n <= 1'b0;
        proc_cycle(1'b1, 16'h5a7d, 16'hfc00);
        `CHK("swapped check out", ~6'h3f, o_board_write_check_n);
        close_cycle();
        proc_cycle(1'b0, 16'h5a7c, 16'h0000);
        close_cycle();
        `CHK("swapped check in", {6'h2d, 10'h3a5}, o_read_bus);
        @(posedge i_clk_sys);
        i_check_swap_test_n <= 1'b1;
    endtask
    task automatic t_count();
        @(posedge i_clk_sys);
        i_proc_load_address <= 16'h12ff;
        i_proc_addr_load_n <= 1'b0;
        @(posedge i_clk_sys);
        i_proc_addr_load_n <= 1'b1;
        repeat (2) @(negedge i_clk_sys);
        `CHK("low carry", 1'b1, o_addr_low_carry_out);
        @(posedge i_clk_sys);
        // three clocks hold exactly one phase-3 step
        i_proc_addr_inc_n <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_proc_addr_inc_n <= 1'b1;
        @(negedge i_clk_sys);
        `CHK("counted address", 16'h1300, o_proc_address);
    endtask
    task automatic t_channel();
        flag_seen = 1'b0;
        @(posedge i_clk_sys);
        i_channel_store <= 1'b1;
        i_channel_address <= 16'h9123;
        i_channel_write_data <= 16'h0f0f;
        i_channel_memory_request_n <= 1'b0;
        wait_st(macc_pkg::ST_SELECT);
        `CHK("chan grant", 1'b1, o_channel_access_grant);
        @(posedge i_clk_sys);
        i_channel_memory_request_n <= 1'b1;
        wait_st(macc_pkg::ST_TRANSFER);
        `CHK("board two", 1'b1, o_board_two_select);
        `CHK("bank two", 3'h1, o_board_two_bank_code);
        `CHK("board three", 1'b0, o_board_three_select);
        `CHK("chan data", ~16'h0f0f, o_board_write_data_n);
        close_cycle();
        `CHK("chan flag", 1'b0, flag_seen);
    endtask
    task automatic t_refresh();
        @(posedge i_clk_sys);
        i_refresh_address <= 6'h2a;
        i_refresh_request <= 1'b1;
        i_proc_cycle_request_n <= 1'b0;
        wait_st(macc_pkg::ST_SELECT);
        `CHK("refresh grants", 2'h0, {o_proc_access_grant, o_channel_access_grant});
        `CHK("refresh start", 1'b0, o_refresh_start_to_boards_n);
        `CHK("channel clock", 1'b0, o_refresh_clock_block_n);
        @(posedge i_clk_sys);
        i_refresh_request <= 1'b0;
        i_proc_cycle_request_n <= 1'b1;
        wait_st(macc_pkg::ST_TRANSFER);
        `CHK("refresh row", ~6'h2a, o_board_word_address_n[11:6]);
        close_cycle();
        // a second refresh may start before grants return
        repeat (20) @(negedge i_clk_sys);
    endtask
    task automatic t_power();
        @(posedge i_clk_sys);
        i_power_failing_n <= 1'b0;
        i_channel_memory_request_n <= 1'b0;
        repeat (8) @(negedge i_clk_sys);
        `CHK("fail grants", 2'h2, {o_proc_access_grant, o_channel_access_grant});
        @(posedge i_clk_sys);
        i_power_failing_n <= 1'b1;
        i_channel_memory_request_n <= 1'b1;
        i_registered_master_reset <= 1'b0;
        repeat (9) @(negedge i_clk_sys);
        `CHK("standby grants", 2'h0, {o_proc_access_grant, o_channel_access_grant});
        `CHK("standby refresh", 1'b0, o_refresh_start_to_boards_n);
        @(posedge i_clk_sys);
        i_registered_master_reset <= 1'b1;
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        // grants start clear, so a refresh cycle may run first
        repeat (24) @(posedge i_clk_sys);
        t_proc();
        t_protect();
        t_swap();
        t_count();
        t_channel();
        t_refresh();
        t_power();
        stop_test();
    end
endmodule
`default_nettype wire
